// ---- logic/tks_pkg.sv ----
// Constants and types for the token semaphore port controller
package tks_pkg;
    localparam int DATA_W      = 36;
    localparam int IDX_W       = 3;
    localparam int FLAG_CNT    = 8;
    localparam int ADDR_W      = 17;
    // Cycle counts of the pin sequence at 40 MHz
    localparam int SETUP_NS    = 10;
    localparam int PULSE_NS    = 50;
    localparam int CLK_NS      = 25;
    localparam int SETUP_CYC   = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int PULSE_CYC   = (PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SYNC_CYC    = 2;
    localparam int READ_CYC    = PULSE_CYC + SYNC_CYC;
    localparam logic [3:0] CNT_RST = 4'h0;
    localparam logic [1:0] OP_WRITE   = 2'h0;
    localparam logic [1:0] OP_READ    = 2'h1;
    localparam logic [1:0] OP_ACQUIRE = 2'h2;
    localparam logic [1:0] OP_INIT    = 2'h3;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_SETUP = 6'h02,
        ST_PULSE = 6'h04,
        ST_GAP   = 6'h08,
        ST_READ  = 6'h10,
        ST_DONE  = 6'h20
    } tks_state_t;
endpackage

// ---- logic/tks_host.sv ----
// Controller driving the semaphore side of one dual-port RAM port
`timescale 1ns/1ps
// What this block does
// - Select semaphore space with select low; index on three low lines.
// - Poll reads must drop select or output enable in between.
// - Acquire by writing zero then reading back; one means failure.
// - After failure, re-read or write one to withdraw.
// - Startup writes one to every semaphore from both sides; this block writes only its own side, and only on the init command.
// - Hold RAM chip select high while semaphore select is low.
module tks_host (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          cmd_valid,
    output logic                               cmd_ready,
    input  wire logic [1:0]                    cmd_op,
    input  wire logic [tks_pkg::IDX_W-1:0]     cmd_index,
    input  wire logic                          cmd_value,
    output logic                               rsp_valid,
    output logic                               rsp_flag,
    output logic                               rsp_granted,
    output logic                               chip_select_n,
    output logic                               token_space_select_n,
    output logic                               write_n,
    output logic                               output_enable_n,
    output logic                               byte_lane_enable_n,
    output logic [tks_pkg::ADDR_W-1:0]         addr,
    output logic [tks_pkg::DATA_W-1:0]         data_out,
    output logic                               data_oe,
    input  wire logic [tks_pkg::DATA_W-1:0]    data_in
);
    typedef struct packed {
        tks_pkg::tks_state_t         st;
        logic [3:0]                  cnt;
        logic [1:0]                  op;
        logic [tks_pkg::IDX_W-1:0]   idx;
        logic                        val;
        logic                        sel_n;
        logic                        we_n;
        logic                        oe_n;
        logic                        drv;
        logic                        rsp_v;
        logic                        flag;
        logic                        grant;
        logic [tks_pkg::DATA_W-1:0]  din_s1;
        logic [tks_pkg::DATA_W-1:0]  din_s2;
    } tks_regs_t;

    tks_regs_t s_r;
    tks_regs_t s_nxt;

    // Flag is read as one only if every data line reads one
    function automatic logic tks_flag_of(input logic [tks_pkg::DATA_W-1:0] d);
        tks_flag_of = &d;
    endfunction

    // Acquire follows its write with a read-back of the same flag
    function automatic logic tks_is_acquire(input logic [1:0] op);
        tks_is_acquire = (op == tks_pkg::OP_ACQUIRE);
    endfunction

    // Init stops after the last flag index
    function automatic logic tks_is_last(input logic [tks_pkg::IDX_W-1:0] i);
        tks_is_last = (i == 3'(tks_pkg::FLAG_CNT - 1));
    endfunction

    // Next value of every register
    always_comb begin
        s_nxt        = s_r;
        s_nxt.rsp_v  = 1'b0;
        // Two flip-flops on the pin data before any logic reads it
        s_nxt.din_s1 = data_in;
        s_nxt.din_s2 = s_r.din_s1;
        unique case (s_r.st)
            // Every command opens with the semaphore space selected
            tks_pkg::ST_IDLE: begin
                if (cmd_valid) begin
                    s_nxt.op    = cmd_op;
                    s_nxt.idx   = cmd_index;
                    s_nxt.val   = cmd_value;
                    s_nxt.sel_n = 1'b0;
                    s_nxt.drv   = 1'b1;
                    s_nxt.cnt   = tks_pkg::CNT_RST;
                    s_nxt.st    = tks_pkg::ST_SETUP;
                    unique case (cmd_op)
                        tks_pkg::OP_WRITE: begin
                            s_nxt.val = cmd_value;
                        end
                        tks_pkg::OP_READ: begin
                            s_nxt.drv = 1'b0;
                            s_nxt.st  = tks_pkg::ST_READ;
                        end
                        tks_pkg::OP_ACQUIRE: begin
                            s_nxt.val = 1'b0;
                        end
                        tks_pkg::OP_INIT: begin
                            s_nxt.idx = '0;
                            s_nxt.val = 1'b1;
                        end
                    endcase
                end
            end

            // Address and data settle before the strobe falls
            tks_pkg::ST_SETUP: begin
                s_nxt.cnt = s_r.cnt + 4'h1;
                if (s_r.cnt == 4'(tks_pkg::SETUP_CYC - 1)) begin
                    s_nxt.we_n = 1'b0;
                    s_nxt.cnt  = tks_pkg::CNT_RST;
                    s_nxt.st   = tks_pkg::ST_PULSE;
                end
            end

            // Write strobe held low for the pulse width
            tks_pkg::ST_PULSE: begin
                s_nxt.cnt = s_r.cnt + 4'h1;
                if (s_r.cnt == 4'(tks_pkg::PULSE_CYC - 1)) begin
                    s_nxt.we_n  = 1'b1;
                    s_nxt.sel_n = 1'b1;
                    s_nxt.cnt   = tks_pkg::CNT_RST;
                    s_nxt.st    = tks_pkg::ST_GAP;
                end
            end

            // Data bus released unless init moves to its next flag; acquire turns round into a read
            tks_pkg::ST_GAP: begin
                s_nxt.drv = 1'b0;
                s_nxt.st  = tks_pkg::ST_DONE;
                if (tks_is_acquire(s_r.op)) begin
                    s_nxt.sel_n = 1'b0;
                    s_nxt.st    = tks_pkg::ST_READ;
                end else if (s_r.op == tks_pkg::OP_INIT &&
                             !tks_is_last(s_r.idx)) begin
                    s_nxt.idx   = s_r.idx + 3'h1;
                    s_nxt.sel_n = 1'b0;
                    s_nxt.drv   = 1'b1;
                    s_nxt.st    = tks_pkg::ST_SETUP;
                end
            end

            // Output latch captures on the falling output enable
            tks_pkg::ST_READ: begin
                s_nxt.oe_n = 1'b0;
                s_nxt.cnt  = s_r.cnt + 4'h1;
                // Extra cycles cover the input synchroniser
                if (s_r.cnt == 4'(tks_pkg::READ_CYC)) begin
                    s_nxt.flag  = tks_flag_of(s_r.din_s2);
                    s_nxt.grant = ~tks_flag_of(s_r.din_s2);
                    s_nxt.oe_n  = 1'b1;
                    s_nxt.sel_n = 1'b1;
                    s_nxt.cnt   = tks_pkg::CNT_RST;
                    s_nxt.st    = tks_pkg::ST_DONE;
                end
            end

            // A lost acquire takes its request back before answering
            tks_pkg::ST_DONE: begin
                if (tks_is_acquire(s_r.op) && !s_r.grant) begin
                    s_nxt.op    = tks_pkg::OP_WRITE;
                    s_nxt.val   = 1'b1;
                    s_nxt.sel_n = 1'b0;
                    s_nxt.drv   = 1'b1;
                    s_nxt.cnt   = tks_pkg::CNT_RST;
                    s_nxt.st    = tks_pkg::ST_SETUP;
                end else begin
                    s_nxt.rsp_v = 1'b1;
                    s_nxt.st    = tks_pkg::ST_IDLE;
                end
            end

            default: begin
                s_nxt.st = tks_pkg::ST_IDLE;
            end
        endcase
    end

    // All state registered here, reset synchronously
    always_ff @(posedge clk) begin
        if (rst) begin
            s_r       <= '0;
            s_r.st    <= tks_pkg::ST_IDLE;
            s_r.sel_n <= 1'b1;
            s_r.we_n  <= 1'b1;
            s_r.oe_n  <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Pins and answers come from registers, except chip select tied high and upper address and data lines tied low
    assign cmd_ready            = (s_r.st == tks_pkg::ST_IDLE);
    assign rsp_valid            = s_r.rsp_v;
    assign rsp_flag             = s_r.flag;
    assign rsp_granted          = s_r.grant;
    assign chip_select_n        = 1'b1;
    assign token_space_select_n = s_r.sel_n;
    assign write_n              = s_r.we_n;
    assign output_enable_n      = s_r.oe_n;
    assign byte_lane_enable_n   = s_r.sel_n;
    assign addr                 = {{(tks_pkg::ADDR_W-tks_pkg::IDX_W){1'b0}},
                                   s_r.idx};
    // Only the lowest data line carries the written value
    assign data_out[0]          = s_r.val;
    for (genvar g = 1; g < tks_pkg::DATA_W; g++) begin : g_dout_zero
        assign data_out[g] = 1'b0;
    end
    assign data_oe              = s_r.drv;
endmodule

// ---- bench/tks_host_monitor.sv ----
// Port timing checks for the semaphore controller
`timescale 1ns/1ps
module tks_host_monitor (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        cmd_valid,
    input wire logic        cmd_ready,
    input wire logic [1:0]  cmd_op,
    input wire logic        rsp_valid,
    input wire logic        chip_select_n,
    input wire logic        token_space_select_n,
    input wire logic        write_n,
    input wire logic        output_enable_n,
    input wire logic        byte_lane_enable_n,
    input wire logic [16:0] addr,
    input wire logic [35:0] data_out,
    input wire logic        data_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_ram_cs_idle:
        assert property (chip_select_n) else $error("cs low");
    a_lane_with_sel:
        assert property (byte_lane_enable_n == token_space_select_n)
        else $error("lane enable mismatch");
    a_upper_addr_zero:
        assert property (!token_space_select_n |-> addr[16:3] == 0)
        else $error("upper address set");
    a_write_bit_only:
        assert property (data_oe |-> data_out[35:1] == 0)
        else $error("upper data driven");
    a_write_in_space:
        assert property (!write_n |-> !token_space_select_n && data_oe &&
            output_enable_n) else $error("bad write strobe");
    a_write_answer:
        assert property (cmd_valid && cmd_ready && cmd_op == 0
            |-> ##[5:7] rsp_valid) else $error("write answer late");
    a_read_answer:
        assert property (cmd_valid && cmd_ready && cmd_op == 1
            |-> ##[6:8] rsp_valid) else $error("read answer late");
    a_sel_drop_between:
        assert property (rsp_valid |-> token_space_select_n)
        else $error("select held across polls");
    a_busy_refuses:
        assert property (cmd_valid && cmd_ready |=> !cmd_ready)
        else $error("ready while busy");
endmodule
bind tks_host tks_host_monitor u_mon (.*);

// ---- bench/tks_dev.sv ----
// Behavioural model of the dual-port semaphore flags
`timescale 1ns/1ps
module tks_dev (
    input wire logic        clk,
    input wire logic        sel_n,
    input wire logic        cs_n,
    input wire logic        we_n,
    input wire logic        oe_n,
    input wire logic        ble_n,
    input wire logic [2:0]  idx,
    input wire logic        d0,
    output logic     [35:0] data_in,
    input wire logic        b_we,
    input wire logic [2:0]  b_idx,
    input wire logic        b_val
);
    logic [1:0] own[8] = '{default: 2'h2};
    logic [7:0] rq_a = 8'h00, rq_b = 8'h00;
    logic       wp = 0, wv, lat, rq = 0, tog = 0;
    logic [2:0] wi;
    wire        rd = !sel_n && !ble_n && !oe_n;
    task automatic wr(input logic s, input logic [2:0] i, input logic v);
        logic [1:0] me;
        logic       orq;
        me = s ? 2'h2 : 2'h1;
        if (s) rq_b[i] = v; else rq_a[i] = v;
        orq = s ? rq_a[i] : rq_b[i];
        if (own[i] == me && v) own[i] = orq ? 2'h0 : 2'h3 - me;
        else if (own[i] == 2'h0 && !v) own[i] = me;
    endtask
    always @(posedge clk) begin
        tog <= !tog;
        if (!we_n && !sel_n && cs_n) begin
            wp = 1; wi = idx; wv = d0;
        end else if (wp) begin
            wp = 0; wr(0, wi, wv);
        end
        if (b_we) wr(1, b_idx, b_val);
        if (rd && !rq) lat <= (own[idx] != 2'h1);
        rq = rd;
    end
    assign data_in = rd ? {36{lat}} : {18{tog, !tog}};
endmodule

// ---- bench/dual_port_token_semaphores_tb.sv ----
// Self-checking bench for the semaphore controller
`timescale 1ns/1ps
module dual_port_token_semaphores_tb;
    logic clk = 0, rst = 1, cmd_valid = 0, cmd_value = 0, b_we = 0, b_val = 0;
    logic [1:0] cmd_op = 0;
    logic [2:0] cmd_index = 0, b_idx = 0, ix;
    logic cmd_ready, rsp_valid, rsp_flag, rsp_granted, cs_n, sel_n, we_n, oe_n;
    logic ble_n, data_oe;
    logic [16:0] addr;
    logic [35:0] data_out, data_in;
    int err_total = 0, tests_run = 0, cyc = 0;
    always #12.5 clk = !clk;
    tks_host i_dut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_index(cmd_index),
        .cmd_value(cmd_value), .rsp_valid(rsp_valid), .rsp_flag(rsp_flag),
        .rsp_granted(rsp_granted), .chip_select_n(cs_n),
        .token_space_select_n(sel_n), .write_n(we_n),
        .output_enable_n(oe_n), .byte_lane_enable_n(ble_n), .addr(addr),
        .data_out(data_out), .data_oe(data_oe), .data_in(data_in));
    tks_dev i_dev (.clk(clk), .sel_n(sel_n), .cs_n(cs_n), .we_n(we_n),
        .oe_n(oe_n), .ble_n(ble_n), .idx(addr[2:0]), .d0(data_out[0]),
        .data_in(data_in), .b_we(b_we), .b_idx(b_idx), .b_val(b_val));
    task automatic chk(input string nm, input logic e, input logic s);
        tests_run++;
        if (e !== s) begin
            $display("[ERR] %s exp %b got %b", nm, e, s);
            err_total++;
        end
    endtask
    task automatic run(input logic [1:0] op, input logic [2:0] i, input logic v);
        int n;
        cmd_op = op; cmd_index = i; cmd_value = v; cmd_valid = 1;
        @(negedge clk);
        cmd_valid = 0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        if (n >= 100) chk("rsp_valid", 1'b1, 1'b0);
    endtask
    task automatic bwr(input logic [2:0] i, input logic v);
        b_idx = i; b_val = v; b_we = 1;
        @(negedge clk);
        b_we = 0;
        @(negedge clk);
    endtask
    task automatic give_verdict;
        $display("tests_run=%0d err_total=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            give_verdict();
        end
    end
    initial begin
        void'($urandom(14126));
        repeat (20) @(negedge clk);
        rst = 0;
        run(2'h3, 3'h0, 1'b1);
        for (int i = 0; i < 8; i++) bwr(i[2:0], 1'b1);
        for (int i = 0; i < 8; i++) begin
            run(2'h1, i[2:0], 1'b0);
            chk("free flag", 1'b1, rsp_flag);
        end
        repeat (6) begin
            ix = 3'($urandom % 8);
            run(2'h2, ix, 1'b0);
            chk("granted", 1'b1, rsp_granted);
            bwr(ix, 1'b0);
            run(2'h1, ix, 1'b0);
            chk("still held", 1'b0, rsp_flag);
            run(2'h0, ix, 1'b1);
            run(2'h1, ix, 1'b0);
            chk("passed over", 1'b1, rsp_flag);
            run(2'h2, ix, 1'b0);
            chk("refused", 1'b0, rsp_granted);
            bwr(ix, 1'b1);
            run(2'h1, ix, 1'b0);
            chk("freed", 1'b1, rsp_flag);
        end
        give_verdict();
    end
endmodule
